// ### hw/cvl_device_end.sv
// convolver end: line store length control, gain control and expansion bus
//
// Overview of operation
// - sync mode: length equals clocks with sync low
// - read old word, then write pixel there
// - sync high blocks writes, clears address
// - address full stops writes, never wraps
// - programmed mode: fall starts, stops at length
// - source uses even lines, loads count minus one
// - frame mode: restart at zero without gap
// - source keeps clock until delayed sync active
// - frame writes run while delayed sync low
// - every clock carries valid data
// - mode C 5:4 picks one of four fields
// - mode C bit0 auto; field output always auto
// - auto picks from top 13/9/5 sign bits
// - program strobe resets auto, ten syncs holdoff
// - field times 4-bit gain, middle sixteen out
// - overflow flag when top four bits spill
// - saturate 11: negatives zero, clamp positive
// - saturate 10: clamp both overflow directions
// - mode B bit4 enables expansion adder
// - master select low: expansion input loads registers
// - 32-bit words split low/high by phase
// - mode A bit7: no multiplex, low sixteen out
// - accumulated sum is 32-bit signed
`timescale 1ns/1ps
module cvl_device_end #(
    parameter int PIX_W = 8,
    parameter int LINE_DEPTH = 1024,
    parameter int DELAYED_SYNC_OUT_DEPTH = cvl_pkg::DELAYED_SYNC_OUT_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    cvl_link_if.dev link,
    input wire logic master_sel_n_i,
    input wire logic [31:0] sum_i,
    output logic [PIX_W-1:0] line_out_o,
    output logic [31:0] cascade_sum_o
);
    localparam int ADDR_W = $clog2(LINE_DEPTH);
    localparam logic [ADDR_W-1:0] ADDR_MAX = ADDR_W'(LINE_DEPTH - 1);

    logic [7:0] mode_a_q;
    logic [7:0] mode_b_q;
    logic [7:0] mode_c_q;
    logic [7:0] mode_d_q;
    logic [3:0] gain_q;
    logic [7:0] len_lo_q;
    logic [1:0] len_hi_q;
    logic sync_q;
    logic sync_fall;
    logic sync_rise;
    logic [ADDR_W-1:0] addr_q;
    logic run_q;
    logic full_q;
    logic wr_en;
    logic [9:0] len;
    logic [PIX_W-1:0] mem [LINE_DEPTH];
    logic [DELAYED_SYNC_OUT_DEPTH-1:0] dsync_q;
    logic phase_q;
    logic [15:0] exp_lo_q;
    logic [31:0] exp_word_q;
    logic signed [31:0] total;
    logic [3:0] hold_cnt_q;
    logic [1:0] auto_q;
    logic [1:0] cand;
    logic [1:0] fsel;
    logic signed [19:0] field;
    logic signed [24:0] prod;
    logic pos_ovf;
    logic neg_ovf;
    logic [15:0] gain_out;
    logic [15:0] bus_q;
    logic ovf_q;
    cvl_pkg::cvl_line_mode_type lmode;

    // ========================================================================
    // register loading
    // ========================================================================
    // master loads {address, data} while strobed
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            mode_a_q <= cvl_pkg::REG_RESET_VAL;
            mode_b_q <= cvl_pkg::REG_RESET_VAL;
            mode_c_q <= cvl_pkg::REG_RESET_VAL;
            mode_d_q <= cvl_pkg::REG_RESET_VAL;
            gain_q <= cvl_pkg::GAIN_RESET_VAL;
            len_lo_q <= cvl_pkg::REG_RESET_VAL;
            len_hi_q <= 2'h0;
        end
        else if (!link.program_strobe_n && !master_sel_n_i)
        begin
            case (link.exp_in[15:8])
                cvl_pkg::REG_MODE_A: mode_a_q <= link.exp_in[7:0];
                cvl_pkg::REG_MODE_B: mode_b_q <= link.exp_in[7:0];
                cvl_pkg::REG_MODE_C: mode_c_q <= link.exp_in[7:0];
                cvl_pkg::REG_MODE_D: mode_d_q <= link.exp_in[7:0];
                cvl_pkg::REG_GAIN: gain_q <= link.exp_in[3:0];
                cvl_pkg::REG_LEN_LO: len_lo_q <= link.exp_in[7:0];
                cvl_pkg::REG_LEN_HI: len_hi_q <= link.exp_in[1:0];
                default: ;
            endcase
        end
    end

    // ========================================================================
    // line store length control
    // ========================================================================
    assign len = {len_hi_q, len_lo_q};
    assign lmode = cvl_pkg::cvl_line_mode_type'(mode_d_q[cvl_pkg::D_LMODE_LSB +: 2]);
    assign sync_fall = sync_q && !link.line_sync_in;
    assign sync_rise = !sync_q && link.line_sync_in;

    // sync edge detect
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            sync_q <= 1'b1;
        else
            sync_q <= link.line_sync_in;
    end

    // write gating per line mode
    always_comb
    begin
        case (lmode)
            cvl_pkg::LM_PROGRAM_STROBE: wr_en = run_q;
            cvl_pkg::LM_FRAME: wr_en = run_q && !link.line_sync_in;
            default: wr_en = !link.line_sync_in && !full_q;
        endcase
    end

    // address counter and run state
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            addr_q <= '0;
            run_q <= 1'b0;
            full_q <= 1'b0;
        end
        else
        begin
            case (lmode)
                cvl_pkg::LM_PROGRAM_STROBE:
                begin
                    full_q <= 1'b0;
                    if (sync_fall)
                    begin
                        addr_q <= '0;
                        run_q <= 1'b1;
                    end
                    else if (run_q)
                    begin
                        if (10'(addr_q) == len || addr_q == ADDR_MAX)
                            run_q <= 1'b0;
                        else
                            addr_q <= addr_q + 1'b1;
                    end
                end
                cvl_pkg::LM_FRAME:
                begin
                    full_q <= 1'b0;
                    if (sync_fall)
                    begin
                        addr_q <= '0;
                        run_q <= 1'b1;
                    end
                    else if (sync_rise)
                        run_q <= 1'b0;
                    else if (run_q)
                    begin
                        if (10'(addr_q) == len || addr_q == ADDR_MAX)
                            addr_q <= '0;
                        else
                            addr_q <= addr_q + 1'b1;
                    end
                end
                default:
                begin
                    run_q <= 1'b0;
                    if (link.line_sync_in)
                    begin
                        addr_q <= '0;
                        full_q <= 1'b0;
                    end
                    else if (wr_en)
                    begin
                        if (addr_q == ADDR_MAX)
                            full_q <= 1'b1;
                        else
                            addr_q <= addr_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // read-first store: the old word leaves before the new pixel lands
    always_ff @(posedge sys_clk_i)
    begin
        line_out_o <= mem[addr_q];
        if (wr_en)
            mem[addr_q] <= link.pixel_in;
    end

    // delayed sync for downstream write and clock gating
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            dsync_q <= '1;
        else
            dsync_q <= {dsync_q[DELAYED_SYNC_OUT_DEPTH-2:0], link.line_sync_in};
    end
    assign link.delayed_sync_out = dsync_q[DELAYED_SYNC_OUT_DEPTH-1];

    // ========================================================================
    // expansion input and adder
    // ========================================================================
    // phase 1 carries the low half, phase 0 the high half
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            phase_q <= 1'b0;
            exp_lo_q <= 16'h0000;
            exp_word_q <= 32'h0000_0000;
        end
        else
        begin
            phase_q <= !phase_q;
            if (mode_a_q[cvl_pkg::A_NO_MUX_BIT])
                exp_word_q <= {{16{link.exp_in[15]}}, link.exp_in};
            else if (phase_q)
                exp_lo_q <= link.exp_in;
            else
                exp_word_q <= {link.exp_in, exp_lo_q};
        end
    end

    // expansion adder, signed 32-bit
    assign total = $signed(sum_i) + (mode_b_q[cvl_pkg::B_EXP_EN_BIT] ?
                   $signed(exp_word_q) : 32'sh0000_0000);

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            cascade_sum_o <= 32'h0000_0000;
        else
            cascade_sum_o <= total;
    end

    // ========================================================================
    // gain control
    // ========================================================================
    assign cand = cvl_pkg::cvl_auto_field(cascade_sum_o);

    // auto field: strobe resets, ten syncs holdoff, then only climbs
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            hold_cnt_q <= cvl_pkg::HOLD_PULSES;
            auto_q <= cvl_pkg::FIELD_LSB;
        end
        else if (!link.program_strobe_n)
        begin
            hold_cnt_q <= cvl_pkg::HOLD_PULSES;
            auto_q <= cvl_pkg::FIELD_LSB;
        end
        else if (hold_cnt_q != 4'h0)
        begin
            if (sync_rise)
                hold_cnt_q <= hold_cnt_q - 4'h1;
        end
        else if (cand < auto_q)
            auto_q <= cand;
    end

    assign fsel = mode_c_q[cvl_pkg::C_AUTO_BIT] ? auto_q :
                  mode_c_q[cvl_pkg::C_FSEL_LSB +: 2];
    assign field = $signed(cascade_sum_o[(31 - cvl_pkg::FIELD_STEP * fsel) -: cvl_pkg::FIELD_W]);
    assign prod = field * $signed({1'b0, gain_q});
    assign pos_ovf = !prod[23] && (prod[22:19] != 4'h0);
    assign neg_ovf = prod[23] && (prod[22:19] != 4'hF);

    // saturation options on the middle sixteen bits
    always_comb
    begin
        case (mode_c_q[cvl_pkg::C_SAT_LSB +: 2])
            cvl_pkg::SAT_DISPLAY: gain_out = prod[23] ? 16'h0000 :
                                  (pos_ovf ? 16'h7FFF : prod[19:4]);
            cvl_pkg::SAT_BOTH: gain_out = pos_ovf ? 16'h7FFF :
                               (neg_ovf ? 16'h8000 : prod[19:4]);
            default: gain_out = prod[19:4];
        endcase
    end

    // output bus: gain result, phased cascade word, or raw low half
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            bus_q <= 16'h0000;
            ovf_q <= 1'b0;
        end
        else
        begin
            ovf_q <= !mode_a_q[cvl_pkg::A_NO_MUX_BIT] && (pos_ovf || neg_ovf);
            if (mode_a_q[cvl_pkg::A_NO_MUX_BIT])
                bus_q <= cascade_sum_o[15:0];
            else if (mode_a_q[cvl_pkg::A_CASCADE_OUT_BIT])
                bus_q <= !phase_q ? cascade_sum_o[15:0] : cascade_sum_o[31:16];
            else
                bus_q <= gain_out;
        end
    end

    assign link.result_out_bus = bus_q;
    assign link.gain_overflow_flag = ovf_q;
    assign link.field_select_out = auto_q;
endmodule : cvl_device_end

// ### hw/cvl_pkg.sv
// shared constants, types and helpers for the convolver ends
package cvl_pkg;
    // ====
    // register map, carried as {address, data} on the expansion input
    localparam logic [7:0] REG_MODE_A = 8'h00;
    localparam logic [7:0] REG_MODE_B = 8'h01;
    localparam logic [7:0] REG_MODE_C = 8'h02;
    localparam logic [7:0] REG_MODE_D = 8'h03;
    localparam logic [7:0] REG_GAIN = 8'h06;
    localparam logic [7:0] REG_LEN_LO = 8'h07;
    localparam logic [7:0] REG_LEN_HI = 8'h08;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [3:0] GAIN_RESET_VAL = 4'h1;
    // ====
    // field positions
    localparam int A_NO_MUX_BIT = 7;
    localparam int A_CASCADE_OUT_BIT = 6;
    localparam int B_EXP_EN_BIT = 4;
    localparam int C_AUTO_BIT = 0;
    localparam int C_FSEL_LSB = 4;
    localparam int C_SAT_LSB = 6;
    localparam int D_LMODE_LSB = 0;
    localparam logic [1:0] SAT_DISPLAY = 2'h3;
    localparam logic [1:0] SAT_BOTH = 2'h2;
    localparam logic [1:0] FIELD_MSB = 2'h0;
    localparam logic [1:0] FIELD_LSB = 2'h3;
    localparam int FIELD_W = 20;
    localparam int FIELD_STEP = 4;
    // ====
    // counts
    localparam logic [3:0] HOLD_PULSES = 4'hA;
    localparam int DELAYED_SYNC_OUT_CYCLES = 29;
    // ========================================================================
    // types
    // ========================================================================
    typedef enum logic [1:0] {LM_SYNC, LM_PROGRAM_STROBE, LM_FRAME} cvl_line_mode_type;
    // automatic field: fewer sign bits picks a higher field
    function automatic logic [1:0] cvl_auto_field(input logic [31:0] s);
        logic [1:0] f;
        f = FIELD_MSB;
        if (s[31:19] == {13{s[31]}}) f = 2'h3;
        else if (s[31:23] == {9{s[31]}}) f = 2'h2;
        else if (s[31:27] == {5{s[31]}}) f = 2'h1;
        return f;
    endfunction : cvl_auto_field
endpackage : cvl_pkg

// ### hw/cvl_link_if.sv
// link between the convolver end and the video source / host end
`timescale 1ns/1ps
interface cvl_link_if #(parameter int PIX_W = 8);
    logic line_sync_in;
    logic [PIX_W-1:0] pixel_in;
    logic program_strobe_n;
    logic [15:0] exp_in;
    logic [15:0] result_out_bus;
    logic [1:0] field_select_out;
    logic gain_overflow_flag;
    logic delayed_sync_out;
    modport dev (
        input line_sync_in, pixel_in, program_strobe_n, exp_in,
        output result_out_bus, field_select_out, gain_overflow_flag, delayed_sync_out
    );
    modport src (
        output line_sync_in, pixel_in, program_strobe_n, exp_in,
        input result_out_bus, field_select_out, gain_overflow_flag, delayed_sync_out
    );
endinterface : cvl_link_if

// ### hw/cvl_source_end.sv
// source end: video/frame-store feed, register loader and cascade bus partner
`timescale 1ns/1ps
module cvl_source_end #(
    parameter int PIX_W = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    cvl_link_if.src link,
    input wire logic cfg_valid_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [7:0] cfg_data_i,
    output logic cfg_ready_o,
    input wire logic line_sync_i,
    input wire logic [PIX_W-1:0] pixel_i,
    input wire logic [31:0] cascade_i,
    input wire logic no_mux_i,
    output logic [31:0] result_o,
    output logic fs_write_en_o,
    output logic clk_stop_ok_o
);
    logic phase_q;
    logic [15:0] exp_q;
    logic strobe_n_q;
    logic sync_q;
    logic [PIX_W-1:0] pix_q;
    logic [15:0] res_lo_q;
    logic [7:0] cfg_byte;

    // ========================================================================
    // register loading and expansion bus drive
    // ========================================================================
    assign cfg_ready_o = 1'b1;
    // length low byte is forced odd: even count minus one
    assign cfg_byte = (cfg_addr_i == cvl_pkg::REG_LEN_LO) ?
                      (cfg_data_i | 8'h01) : cfg_data_i;

    // one strobed word per accepted write, else the phased cascade word, or its low half with no_mux_i
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            phase_q <= 1'b0;
            exp_q <= 16'h0000;
            strobe_n_q <= 1'b1;
        end
        else
        begin
            phase_q <= !phase_q;
            strobe_n_q <= !cfg_valid_i;
            if (cfg_valid_i)
                exp_q <= {cfg_addr_i, cfg_byte};
            else if (no_mux_i)
                exp_q <= cascade_i[15:0];
            else
                exp_q <= !phase_q ? cascade_i[15:0] : cascade_i[31:16];
        end
    end

    // pixel and sync feed: every cycle is a valid pixel
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            sync_q <= 1'b1;
            pix_q <= '0;
        end
        else
        begin
            sync_q <= line_sync_i;
            pix_q <= pixel_i;
        end
    end

    assign link.exp_in = exp_q;
    assign link.program_strobe_n = strobe_n_q;
    assign link.line_sync_in = sync_q;
    assign link.pixel_in = pix_q;

    // ========================================================================
    // result capture and frame-store control
    // ========================================================================
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            res_lo_q <= 16'h0000;
            result_o <= 32'h0000_0000;
            fs_write_en_o <= 1'b0;
            clk_stop_ok_o <= 1'b1;
        end
        else
        begin
            fs_write_en_o <= !link.delayed_sync_out;
            clk_stop_ok_o <= link.delayed_sync_out;
            if (no_mux_i)
                result_o <= {{16{link.result_out_bus[15]}}, link.result_out_bus};
            else if (phase_q)
                res_lo_q <= link.result_out_bus;
            else
                result_o <= {link.result_out_bus, res_lo_q};
        end
    end
endmodule : cvl_source_end

// ### tb/cvl_link_checker.sv
// concurrent checks on the convolver link
`timescale 1ns/1ps
module cvl_link_checker #(
    parameter int DELAYED_SYNC_OUT_DEPTH = 29
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic line_sync_in,
    input wire logic program_strobe_n,
    input wire logic [15:0] exp_in,
    input wire logic [15:0] result_out_bus,
    input wire logic [1:0] field_select_out,
    input wire logic gain_overflow_flag,
    input wire logic delayed_sync_out
);
    logic [7:0] mode_a_q;
    logic [7:0] mode_c_q;
    logic [5:0] age_q;
    logic [5:0] run_q;
    logic [3:0] syncs_q;
    logic sync_prev_q;
    logic gain_path;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // ====
    // helper state
    // mode register shadow
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            mode_a_q <= 8'h00;
            mode_c_q <= 8'h00;
        end
        else if (!program_strobe_n && exp_in[15:8] == cvl_pkg::REG_MODE_A)
            mode_a_q <= exp_in[7:0];
        else if (!program_strobe_n && exp_in[15:8] == cvl_pkg::REG_MODE_C)
            mode_c_q <= exp_in[7:0];
    end
    // age and sync rises since a write
    always_ff @(posedge sys_clk_i)
    begin
        sync_prev_q <= line_sync_in;
        if (rst_i || !program_strobe_n)
        begin
            age_q <= 6'h00;
            syncs_q <= 4'h0;
        end
        else
        begin
            if (age_q != 6'h3F)
                age_q <= age_q + 6'h01;
            if (line_sync_in && !sync_prev_q && syncs_q != 4'hF)
                syncs_q <= syncs_q + 4'h1;
        end
    end
    // cycles since reset
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
            run_q <= 6'h00;
        else if (run_q != 6'h3F)
            run_q <= run_q + 6'h01;
    end
    // bus shows a settled gain result
    assign gain_path = mode_a_q[7:6] == 2'h0 && age_q > 6'h03;
    // ====
    // assertions
    AST_DELAYED_SYNC: assert property (
        run_q == 6'h3F |-> delayed_sync_out == $past(line_sync_in, DELAYED_SYNC_OUT_DEPTH))
        else $error("delayed sync off");
    AST_FIELD_RESET: assert property (
        !program_strobe_n |-> ##2 field_select_out == 2'h3)
        else $error("field not reset");
    AST_HOLDOFF: assert property (
        age_q > 6'h02 && syncs_q < 4'h9 |-> field_select_out == 2'h3)
        else $error("field moved in holdoff");
    AST_CLIMB: assert property (
        age_q > 6'h03 |-> field_select_out <= $past(field_select_out))
        else $error("field dropped");
    AST_NARROW_NO_OVF: assert property (
        mode_a_q[7] && age_q > 6'h03 |-> !gain_overflow_flag)
        else $error("narrow overflow");
    AST_DISPLAY_SIGN: assert property (
        gain_path && mode_c_q[7:6] == 2'h3 |-> !result_out_bus[15])
        else $error("display negative");
    AST_DISPLAY_CLAMP: assert property (
        gain_path && mode_c_q[7:6] == 2'h3 && gain_overflow_flag
        |-> result_out_bus inside {16'h7FFF, 16'h0000})
        else $error("display unclamped");
    AST_BOTH_CLAMP: assert property (
        gain_path && mode_c_q[7:6] == 2'h2 && gain_overflow_flag
        |-> result_out_bus inside {16'h7FFF, 16'h8000})
        else $error("overflow unclamped");
    // main scenarios reached
    COV_OVF_BOTH: cover property (gain_path && mode_c_q[7:6] == 2'h2 && gain_overflow_flag);
    COV_CLIMB: cover property (field_select_out < $past(field_select_out));
    COV_NARROW: cover property (mode_a_q[7] && age_q == 6'h3F);
endmodule : cvl_link_checker

// ### tb/convolver_line_delay_gain_expansion_test.sv
// self-checking bench for the two convolver ends
`timescale 1ns/1ps
module convolver_line_delay_gain_expansion_test;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg_valid = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_data = 8'h00;
    logic line_sync = 1'b1;
    logic [7:0] pixel = 8'h00;
    logic [31:0] cascade = 32'h0000_0000;
    logic no_mux = 1'b0;
    logic [31:0] sum = 32'h0000_0000;
    logic [7:0] line_out;
    logic [31:0] cascade_sum, result, s, e;
    logic [16:0] gain_seen;
    logic fs_we, clk_ok;
    integer seed = 74;
    int mismatches = 0, checks = 0;
    logic [7:0] mem [16];
    logic [15:0] ok;
    logic [3:0] addr = 4'h0, len, gain;
    logic stop = 1'b0;
    logic [1:0] lmode, lv, gv, fexp;
    logic [7:0] mode_a = 8'h00, mode_c;
    logic [1:0][7:0] lexp;
    logic [1:0][16:0] gexp;
    logic [31:0] auto_sums [4] = '{32'h0000_0100, 32'h0010_0000, 32'h0000_0100, 32'hF000_0000};
    // ====
    // the two ends, the link and the checker
    cvl_link_if link ();
    assign gain_seen = {link.gain_overflow_flag, link.result_out_bus};
    cvl_source_end u_cvl_source_end (
        .sys_clk_i(sys_clk), .rst_i(rst), .link(link), .cfg_valid_i(cfg_valid),
        .cfg_addr_i(cfg_addr), .cfg_data_i(cfg_data), .cfg_ready_o(), .line_sync_i(line_sync),
        .pixel_i(pixel), .cascade_i(cascade), .no_mux_i(no_mux), .result_o(result),
        .fs_write_en_o(fs_we), .clk_stop_ok_o(clk_ok));
    cvl_device_end #(.LINE_DEPTH(16), .DELAYED_SYNC_OUT_DEPTH(29)) u_cvl_device_end (
        .sys_clk_i(sys_clk), .rst_i(rst), .link(link), .master_sel_n_i(1'b0),
        .sum_i(sum), .line_out_o(line_out), .cascade_sum_o(cascade_sum));
    cvl_link_checker #(.DELAYED_SYNC_OUT_DEPTH(29)) u_cvl_link_checker (
        .sys_clk_i(sys_clk), .rst_i(rst), .line_sync_in(link.line_sync_in),
        .program_strobe_n(link.program_strobe_n), .exp_in(link.exp_in),
        .result_out_bus(link.result_out_bus), .field_select_out(link.field_select_out),
        .gain_overflow_flag(link.gain_overflow_flag), .delayed_sync_out(link.delayed_sync_out));
    // 125 MHz pixel clock
    always #4 sys_clk = ~sys_clk;
    // ====
    // expectation, compare and drive tasks
    function automatic logic [16:0] gain_exp(input logic [31:0] v);
        logic signed [19:0] f;
        logic signed [23:0] p;
        logic [16:0] r;
        f = v[31 - 4 * mode_c[5:4] -: 20];
        p = f * $signed({1'b0, gain});
        r = {p[23:19] != {5{p[23]}}, p[19:4]};
        if (mode_c[7:6] == 2'h3 && p[23])
            r[15:0] = 16'h0000;
        else if (mode_c[7] && r[16])
            r[15:0] = (p[23] && mode_c[7:6] == 2'h2) ? 16'h8000 : 16'h7FFF;
        return r;
    endfunction : gain_exp
    // narrowest signed range picks the field
    function automatic logic [1:0] auto_of(input logic [31:0] v);
        for (int k = 3; k > 0; k--)
            if ($signed(v) >= -(32'sh1 <<< (31 - 4 * k)) && $signed(v) < (32'sh1 <<< (31 - 4 * k)))
                return 2'(k);
        return 2'h0;
    endfunction : auto_of
    task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_val
    // one register write, shadowed
    task automatic cfg(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        cfg_valid = 1'b1;
        cfg_addr = a;
        cfg_data = d;
        @(negedge sys_clk);
        cfg_valid = 1'b0;
        repeat (3) @(negedge sys_clk);
        case (a)
            cvl_pkg::REG_MODE_A: mode_a = d;
            cvl_pkg::REG_MODE_C: mode_c = d;
            cvl_pkg::REG_MODE_D: lmode = d[1:0];
            cvl_pkg::REG_GAIN: gain = d[3:0];
            cvl_pkg::REG_LEN_LO: len = d[3:0] | 4'h1;
            default: ;
        endcase
        ok = 16'h0000;
        lv = 2'h0;
        gv = 2'h0;
    endtask : cfg
    // one pixel clock: check, drive, model
    task automatic step(input logic sync, input logic [7:0] pix, input logic [31:0] v);
        @(negedge sys_clk);
        if (lv[1]) cmp_val("line_out", {24'h0, lexp[1]}, {24'h0, line_out});
        if (gv[1]) cmp_val("gain_out", {15'h0, gexp[1]}, {15'h0, gain_seen});
        lv[1] = lv[0];
        lexp[1] = lexp[0];
        gv[1] = gv[0];
        gexp[1] = gexp[0];
        line_sync = sync;
        pixel = pix;
        sum = v;
        lv[0] = 1'b0;
        gv[0] = mode_a[7:6] == 2'h0 && !mode_c[0];
        gexp[0] = gain_exp(v);
        if (sync)
        begin
            addr = 4'h0;
            stop = 1'b0;
        end
        else if (!stop)
        begin
            lv[0] = ok[addr] && (lmode == 2'h0 || addr != 4'h0);
            lexp[0] = mem[addr];
            mem[addr] = pix;
            ok[addr] = 1'b1;
            if (addr != ((lmode == 2'h0) ? 4'hF : len))
                addr = addr + 4'h1;
            else if (lmode == 2'h2)
                addr = 4'h0;
            else
                stop = 1'b1;
        end
    endtask : step
    task automatic line(input int n, input logic [31:0] v, input bit rnd);
        repeat (n) step(1'b0, 8'($random(seed)), rnd ? 32'($random(seed)) : v);
        repeat (3) step(1'b1, 8'($random(seed)), rnd ? 32'($random(seed)) : v);
    endtask : line
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // ====
    // main sequence and watchdog
    // watchdog: the sequence needs about 820 cycles
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish();
    end
    initial
    begin
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        cfg(cvl_pkg::REG_LEN_LO, 8'h05);
        cfg(cvl_pkg::REG_LEN_HI, 8'h00);
        // every line mode, field and saturation code
        for (int m = 0; m < 3; m++)
            for (int k = 0; k < 4; k++)
            begin
                cfg(cvl_pkg::REG_MODE_D, 8'(m));
                cfg(cvl_pkg::REG_MODE_C, {2'(k + 1), 2'(k + m), 4'h0});
                cfg(cvl_pkg::REG_GAIN, 8'($random(seed)) & 8'h0F);
                repeat (2) line((m == 0) ? 10 + 4 * k : (m == 1) ? 9 : 20, 32'h0, 1'b1);
            end
        // automatic field: holdoff, climb, reset by a write
        cfg(cvl_pkg::REG_MODE_C, 8'h01);
        fexp = 2'h3;
        for (int j = 0; j < 14; j++)
        begin
            s = (j < 11) ? auto_sums[0] : auto_sums[j - 10];
            line(6, s, 1'b0);
            if (j >= 10)
            begin
                if (auto_of(s) < fexp)
                    fexp = auto_of(s);
                cmp_val("field_select", {30'h0, fexp}, {30'h0, link.field_select_out});
            end
        end
        cfg(cvl_pkg::REG_MODE_C, 8'h01);
        cmp_val("field_reset", 32'h3, {30'h0, link.field_select_out});
        // expansion adder off and on, phased and narrow output
        for (int i = 0; i < 3; i++)
        begin
            no_mux = i == 2;
            cfg(cvl_pkg::REG_MODE_A, (i == 2) ? 8'h80 : 8'h40);
            cfg(cvl_pkg::REG_MODE_B, (i == 1) ? 8'h10 : 8'h00);
            cascade = $random(seed);
            s = $random(seed);
            e = (i == 1) ? s + cascade : s;
            repeat (10) step(1'b1, 8'h00, s);
            cmp_val("cascade_sum", e, cascade_sum);
            if (i < 2)
                cmp_val("result", e, result);
            else
                cmp_val("narrow", {16'h0, e[15:0]}, {16'h0, link.result_out_bus});
        end
        cmp_val("fs_write_en", 32'h0, {31'h0, fs_we});
        cmp_val("clk_stop_ok", 32'h1, {31'h0, clk_ok});
        tally_and_finish();
    end
endmodule : convolver_line_delay_gain_expansion_test
